/* hw/fsvh_top.sv */
// Special-value classification, NaN handling, subnormal overrides and flag register with an Avalon-MM slave.
//
// Function
// - Zero exponent and mantissa decode as signed zero.
// - Ones exponent, zero mantissa decode as signed infinity.
// - Ones exponent, clear mantissa MSB, nonzero rest: signaling.
// - Ones exponent, mantissa MSB set: quiet NaN.
// - Zero exponent, nonzero mantissa: signed subnormal.
// - Single uses 8-bit biased exponent; fixed subnormal Emin.
// - Signaling NaN source raises invalid, yields quiet NaN.
// - No source NaN on error gives default NaN.
// - Propagate source NaN payloads, quieting signaling ones.
// - Fused zero times infinity product is default NaN.
// - Out-of-range conversion raises huge integer, not invalid.
// - Converting NaN or infinity raises invalid, not huge integer.
// - Subnormal result sets underflow and its sticky.
// - Subnormal operand without zeroing sets operand flags.
// - Zeroing replaces subnormal operands with signed zero.
// - Moves, logic, test, compare, conversions-in exempt.
// - Flushing needs flush bit and underflow mask.
// - Below smallest subnormal rounds to zero, flags.
// - Flushed subnormal becomes signed zero, underflow, inexact.
// - Flush bit sampled only at write-back.
// - Zeroed operand never raises subnormal operand flag.
// - Exception event forwarded only when unmasked.
// - Sticky flags cleared only by reset or software.
module fsvh_top
  import fsvh_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                req_valid_i,
  input  wire fsvh_pkg::fsvh_req_t req_i,
  output fsvh_pkg::fsvh_iss_t      iss_o,
  input  wire fsvh_pkg::fsvh_fu_t  fu_i,
  output fsvh_pkg::fsvh_wb_t       wb_o,
  output logic                     exc_event_o
);
  import fsvh_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] rdata_reg;
  logic        waitreq_reg;
  logic        acc_take;
  logic [31:0] wmask;

  typedef struct packed {
    logic        valid;
    fsvh_op_t    op;
    logic        dp;
    logic        nan_valid;
    logic [63:0] nan_val;
    logic        invalid;
    logic        subop;
    logic        conv_special;
  } fsvh_ex_t;

  fsvh_ex_t    ex_reg;
  fsvh_ex_t    ex_next;
  fsvh_iss_t   iss_reg;
  fsvh_iss_t   iss_next;
  fsvh_wb_t    wb_reg;
  fsvh_wb_t    wb_next;
  logic        event_reg;
  logic        event_next;

  fsvh_cls_t   ca;
  fsvh_cls_t   cb;
  fsvh_cls_t   cc;
  fsvh_cls_t   cr;
  logic        exempt;
  logic        zeroing;
  logic        use_b;
  logic        use_c;
  logic        is_conv;
  logic        nan_op;
  logic        prod_err;
  logic [63:0] prod_nan;
  logic        prod_is_nan;
  logic        prod_is_q;
  logic        flush_on;
  logic [6:0]  flags;

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = waitreq_reg;
  assign iss_o             = iss_reg;
  assign wb_o              = wb_reg;
  assign exc_event_o       = event_reg;
  assign acc_take          = (avs_read_i || avs_write_i) && !waitreq_reg;
  assign wmask             = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                              {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  function automatic logic [63:0] quiet(input logic [63:0] v, input logic dp);
    return v | (dp ? DP_QUIET_MASK : SP_QUIET_MASK);
  endfunction

  // Picks the NaN to pass on: quiet beats signaling, then larger significand.
  function automatic logic [63:0] pick_nan(input logic [63:0] va, input fsvh_cls_t a,
                                           input logic [63:0] vb, input fsvh_cls_t b,
                                           input logic dp);
    logic na;
    logic nb;
    logic [63:0] r;
    na = a.qnan | a.snan;
    nb = b.qnan | b.snan;
    if (na && nb) begin
      if (a.qnan && !b.qnan) begin
        r = va;
      end else if (b.qnan && !a.qnan) begin
        r = vb;
      end else begin
        r = (fsvh_mant(va, dp) >= fsvh_mant(vb, dp)) ? va : vb;
      end
    end else if (na) begin
      r = va;
    end else begin
      r = vb;
    end
    return quiet(r, dp);
  endfunction

  // Avalon-MM slave: every access is answered one cycle after it is seen.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end else if (ce_i) begin
      waitreq_reg <= !((avs_read_i || avs_write_i) && waitreq_reg);
      if (avs_read_i && waitreq_reg) begin
        case (avs_address_i)
          CTRL_ADDR: rdata_reg <= ctrl_reg;
          STAT_ADDR: rdata_reg <= stat_reg;
          default:   rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ce_i && acc_take && avs_write_i && avs_address_i == CTRL_ADDR) begin
      ctrl_reg <= (ctrl_reg & ~(wmask & CTRL_WMASK)) | (avs_writedata_i & wmask & CTRL_WMASK);
    end
  end

  // Status: a hardware set in the same cycle as a software write wins.
  always_comb begin
    stat_next = stat_reg;
    if (acc_take && avs_write_i && avs_address_i == STAT_ADDR) begin
      stat_next = (stat_reg & ~(wmask & STAT_WMASK)) | (avs_writedata_i & wmask & STAT_WMASK);
    end
    if (wb_next.valid) begin
      stat_next[6:0]                       = wb_next.flags;
      stat_next[STICKY_LSB+6:STICKY_LSB]   = stat_next[STICKY_LSB+6:STICKY_LSB] | wb_next.flags;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stat_reg <= STAT_RESET;
    end else if (ce_i) begin
      stat_reg <= stat_next;
    end
  end

  // Issue stage: classify, zero subnormal operands, resolve NaN results.
  always_comb begin
    ca       = fsvh_classify(req_i.a, req_i.dp);
    cb       = fsvh_classify(req_i.b, req_i.dp);
    cc       = fsvh_classify(req_i.c, req_i.dp);
    exempt   = 1'b0;
    use_b    = 1'b1;
    use_c    = 1'b0;
    is_conv  = 1'b0;
    nan_op   = 1'b0;
    case (req_i.op)
      register_move_op, conditional_move_op, bitwise_and_op, bitwise_or_op, operand_test_op,
      int32_to_float_op, int64_to_float_op, signaling_compare_op, quiet_compare_op, transfer_op: begin
        exempt = 1'b1;
      end
      fused_multiply_accumulate: begin
        use_c  = 1'b1;
        nan_op = 1'b1;
      end
      float_to_int32_op, float_to_int64_op: begin
        is_conv = 1'b1;
        use_b   = 1'b0;
      end
      absolute_value_op, negate_op: begin
        use_b = 1'b0;
      end
      arith_op: begin
        nan_op = 1'b1;
      end
      default: begin
        exempt = 1'b1;
      end
    endcase
    if (req_i.op == int32_to_float_op || req_i.op == int64_to_float_op || req_i.op == operand_test_op) begin
      use_b = 1'b0;
    end
    zeroing                   = ctrl_reg[CTRL_ZERO_BIT] && !exempt;
    iss_next.valid            = req_valid_i;
    iss_next.op               = req_i.op;
    iss_next.dp               = req_i.dp;
    iss_next.rnd              = ctrl_reg[CTRL_RND_LSB+1:CTRL_RND_LSB];
    iss_next.a                = (zeroing && ca.sub) ? fsvh_signed_zero(ca.sign, req_i.dp) : req_i.a;
    iss_next.b                = (zeroing && cb.sub) ? fsvh_signed_zero(cb.sign, req_i.dp) : req_i.b;
    iss_next.c                = (zeroing && cc.sub) ? fsvh_signed_zero(cc.sign, req_i.dp) : req_i.c;
    prod_err    = (ca.zero && cb.inf) || (ca.inf && cb.zero)
                  || (zeroing && ((ca.sub && cb.inf) || (ca.inf && cb.sub)));
    prod_is_nan = prod_err || ca.qnan || ca.snan || cb.qnan || cb.snan;
    prod_nan    = prod_err ? (req_i.dp ? DP_DEFAULT_NAN : SP_DEFAULT_NAN)
                           : pick_nan(req_i.a, ca, req_i.b, cb, req_i.dp);
    prod_is_q   = prod_err || ca.qnan || cb.qnan;
    ex_next.valid        = req_valid_i;
    ex_next.op           = req_i.op;
    ex_next.dp           = req_i.dp;
    ex_next.nan_valid    = 1'b0;
    ex_next.nan_val      = 64'h0;
    ex_next.conv_special = is_conv && (ca.qnan || ca.snan || ca.inf);
    ex_next.subop        = !exempt && !zeroing
                           && (ca.sub || (use_b && cb.sub) || (use_c && cc.sub));
    ex_next.invalid      = ex_next.conv_special
                           || (!exempt && (ca.snan || (use_b && cb.snan) || (use_c && cc.snan)))
                           || (req_i.op == signaling_compare_op && (ca.qnan | ca.snan | cb.qnan | cb.snan))
                           || (req_i.op == quiet_compare_op && (ca.snan | cb.snan))
                           || (req_i.op == fused_multiply_accumulate && prod_err);
    if (nan_op && !use_c) begin
      ex_next.nan_valid = prod_is_nan;
      ex_next.nan_val   = prod_nan;
    end else if (nan_op) begin
      ex_next.nan_valid = prod_is_nan || cc.qnan || cc.snan;
      if (!prod_is_nan) begin
        ex_next.nan_val = quiet(req_i.c, req_i.dp);
      end else if (!(cc.qnan || cc.snan) || (prod_is_q && !cc.qnan)) begin
        ex_next.nan_val = prod_nan;
      end else if (cc.qnan && !prod_is_q) begin
        ex_next.nan_val = quiet(req_i.c, req_i.dp);
      end else begin
        ex_next.nan_val = (fsvh_mant(prod_nan, req_i.dp) >= fsvh_mant(req_i.c, req_i.dp))
                          ? prod_nan : quiet(req_i.c, req_i.dp);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      iss_reg <= '0;
      ex_reg  <= '0;
    end else if (ce_i) begin
      iss_reg <= iss_next;
      ex_reg  <= ex_next;
    end
  end

  // Write-back stage: flush control is read from the control register here only.
  always_comb begin
    cr       = fsvh_classify(fu_i.result, ex_reg.dp);
    flush_on = ctrl_reg[CTRL_FLUSH_BIT] && ctrl_reg[FLAG_UNDERFLOW];
    flags    = 7'h00;
    flags[FLAG_INVALID] = ex_reg.invalid;
    flags[FLAG_SUBOP]   = ex_reg.subop;
    wb_next.valid  = ex_reg.valid;
    wb_next.result = fu_i.result;
    if (ex_reg.nan_valid) begin
      wb_next.result = ex_reg.nan_val;
    end else if (ex_reg.op == float_to_int32_op || ex_reg.op == float_to_int64_op) begin
      flags[FLAG_HUGE]    = fu_i.out_of_range && !ex_reg.conv_special;
      flags[FLAG_INEXACT] = fu_i.inexact;
    end else if (ex_reg.op == arith_op || ex_reg.op == fused_multiply_accumulate
                 || ex_reg.op == int32_to_float_op || ex_reg.op == int64_to_float_op) begin
      flags[FLAG_INEXACT] = fu_i.inexact;
      if (fu_i.tiny) begin
        wb_next.result        = fsvh_signed_zero(cr.sign, ex_reg.dp);
        flags[FLAG_UNDERFLOW] = 1'b1;
        flags[FLAG_INEXACT]   = 1'b1;
      end else if (cr.sub) begin
        flags[FLAG_UNDERFLOW] = 1'b1;
        if (flush_on) begin
          wb_next.result      = fsvh_signed_zero(cr.sign, ex_reg.dp);
          flags[FLAG_INEXACT] = 1'b1;
        end
      end
    end
    wb_next.flags = flags;
    event_next    = ex_reg.valid && (|(flags & ~ctrl_reg[6:0]));
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_reg    <= '0;
      event_reg <= 1'b0;
    end else if (ce_i) begin
      wb_reg    <= wb_next;
      event_reg <= event_next;
    end
  end

  // Checks on the produced values and flags.
  fsvh_cls_t chk_r;
  assign chk_r = fsvh_classify(wb_reg.result, 1'b0);

  no_snan_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wb_reg.valid && wb_reg.flags[FLAG_INVALID] && $past(ex_reg.nan_valid) && !$past(ex_reg.dp) |-> !chk_r.snan)
    else $error("signaling NaN left the block");

  fma_default_nan_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req_valid_i && req_i.op == fused_multiply_accumulate && !req_i.dp && req_i.a[30:0] == 31'h0
    && req_i.b[30:0] == 31'h7F80_0000 && req_i.c[30:23] != 8'hFF ##1 ce_i
    |=> wb_reg.result == SP_DEFAULT_NAN)
    else $error("zero times infinity did not give the default NaN");

  zero_operand_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req_valid_i && req_i.op == arith_op && ctrl_reg[CTRL_ZERO_BIT] && !req_i.dp
    && req_i.a[30:23] == 8'h00 && req_i.a[22:0] != 23'h0 |=> iss_reg.a[30:0] == 31'h0)
    else $error("subnormal operand not zeroed");

  exempt_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req_valid_i && req_i.op == register_move_op |=> iss_reg.a == $past(req_i.a) && !ex_reg.subop)
    else $error("override applied to exempt op");

  subop_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && ex_reg.valid && ex_reg.subop |=> wb_reg.flags[FLAG_SUBOP] && stat_reg[STICKY_LSB+FLAG_SUBOP])
    else $error("subnormal operand flags not set");

  zeroing_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req_valid_i && ctrl_reg[CTRL_ZERO_BIT] |=> !ex_reg.subop)
    else $error("subnormal operand flagged while zeroing");

  huge_excl_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wb_reg.valid |-> !(wb_reg.flags[FLAG_HUGE] && wb_reg.flags[FLAG_INVALID]))
    else $error("huge integer raised with invalid");

  sticky_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    stat_reg[STICKY_LSB+FLAG_UNDERFLOW] && !(acc_take && avs_write_i) |=> stat_reg[STICKY_LSB+FLAG_UNDERFLOW])
    else $error("sticky flag cleared by hardware");

  flush_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && ex_reg.valid && !ex_reg.nan_valid && !fu_i.tiny && cr.sub && ex_reg.op == arith_op
    && !ctrl_reg[FLAG_UNDERFLOW] |=> wb_reg.result == $past(fu_i.result))
    else $error("flush applied with underflow unmasked");

  event_mask_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    exc_event_o |-> |(wb_reg.flags & ~$past(ctrl_reg[6:0])))
    else $error("masked exception forwarded");

  underflow_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && ex_reg.valid && !ex_reg.nan_valid && ex_reg.op == arith_op && cr.sub
    |=> wb_reg.flags[FLAG_UNDERFLOW] && stat_reg[STICKY_LSB+FLAG_UNDERFLOW])
    else $error("subnormal result did not raise underflow");

  flush_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && ex_reg.valid && !ex_reg.nan_valid && !ex_reg.dp && ex_reg.op == arith_op && cr.sub
    && ctrl_reg[CTRL_FLUSH_BIT] && ctrl_reg[FLAG_UNDERFLOW]
    |=> wb_reg.result[30:0] == 31'h0 && wb_reg.flags[FLAG_INEXACT])
    else $error("subnormal result not flushed");

  conv_invalid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && ex_reg.valid && ex_reg.conv_special |=> wb_reg.flags[FLAG_INVALID] && !wb_reg.flags[FLAG_HUGE])
    else $error("special conversion source flagged wrongly");

endmodule // fsvh_top

/* hw/fsvh_pkg.sv */
// Package with constants, types and helper functions for the special-value handling block.
package fsvh_pkg;

  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  STAT_ADDR      = 4'h4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK     = 32'h0000_0F7F;
  localparam logic [31:0] STAT_WMASK     = 32'h0000_7F7F;
  localparam int          CTRL_RND_LSB   = 8;
  localparam int          CTRL_FLUSH_BIT = 10;
  localparam int          CTRL_ZERO_BIT  = 11;
  localparam int          STICKY_LSB     = 8;
  localparam int          FLAG_INVALID   = 0;
  localparam int          FLAG_UNDERFLOW = 3;
  localparam int          FLAG_INEXACT   = 4;
  localparam int          FLAG_HUGE      = 5;
  localparam int          FLAG_SUBOP     = 6;

  localparam int          SP_SIGN        = 31;
  localparam int          SP_EXP_MSB     = 30;
  localparam int          SP_EXP_LSB     = 23;
  localparam int          SP_MAN_MSB     = 22;
  localparam int          SP_EXP_BIAS    = 127;
  localparam int          SP_EMIN        = -126;
  localparam int          DP_SIGN        = 63;
  localparam int          DP_EXP_MSB     = 62;
  localparam int          DP_EXP_LSB     = 52;
  localparam int          DP_MAN_MSB     = 51;
  localparam int          DP_EMIN        = -1023;
  localparam logic [63:0] SP_DEFAULT_NAN = 64'h0000_0000_7FC0_0001;
  localparam logic [63:0] DP_DEFAULT_NAN = 64'h7FF8_0000_0000_0001;
  localparam logic [63:0] SP_QUIET_MASK  = 64'h0000_0000_0040_0000;
  localparam logic [63:0] DP_QUIET_MASK  = 64'h0008_0000_0000_0000;

  typedef enum logic [3:0] {
    arith_op, fused_multiply_accumulate, float_to_int32_op, float_to_int64_op,
    int32_to_float_op, int64_to_float_op, absolute_value_op, negate_op,
    register_move_op, conditional_move_op, bitwise_and_op, bitwise_or_op,
    operand_test_op, signaling_compare_op, quiet_compare_op, transfer_op
  } fsvh_op_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic inf;
    logic snan;
    logic qnan;
    logic sub;
  } fsvh_cls_t;

  typedef struct packed {
    fsvh_op_t    op;
    logic        dp;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] c;
  } fsvh_req_t;

  typedef struct packed {
    logic        valid;
    fsvh_op_t    op;
    logic        dp;
    logic [1:0]  rnd;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] c;
  } fsvh_iss_t;

  typedef struct packed {
    logic [63:0] result;
    logic        tiny;
    logic        inexact;
    logic        out_of_range;
  } fsvh_fu_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] result;
    logic [6:0]  flags;
  } fsvh_wb_t;

  function automatic fsvh_cls_t fsvh_classify(input logic [63:0] v, input logic dp);
    fsvh_cls_t c;
    logic      e_one;
    logic      e_zero;
    logic      m_zero;
    logic      m_msb;
    c.sign = dp ? v[DP_SIGN] : v[SP_SIGN];
    e_one  = dp ? (&v[DP_EXP_MSB:DP_EXP_LSB]) : (&v[SP_EXP_MSB:SP_EXP_LSB]);
    e_zero = dp ? ~(|v[DP_EXP_MSB:DP_EXP_LSB]) : ~(|v[SP_EXP_MSB:SP_EXP_LSB]);
    m_zero = dp ? ~(|v[DP_MAN_MSB:0]) : ~(|v[SP_MAN_MSB:0]);
    m_msb  = dp ? v[DP_MAN_MSB] : v[SP_MAN_MSB];
    c.zero = e_zero & m_zero;
    c.sub  = e_zero & ~m_zero;
    c.inf  = e_one & m_zero;
    c.qnan = e_one & m_msb;
    c.snan = e_one & ~m_msb & ~m_zero;
    return c;
  endfunction

  function automatic logic [63:0] fsvh_signed_zero(input logic s, input logic dp);
    return dp ? {s, 63'h0} : {32'h0, s, 31'h0};
  endfunction

  function automatic logic [51:0] fsvh_mant(input logic [63:0] v, input logic dp);
    return dp ? v[DP_MAN_MSB:0] : {29'h0, v[SP_MAN_MSB:0]};
  endfunction

endpackage

/* verif/fsvh_fu_model.sv */
// Functional block stand-in that answers each issued operation in the same cycle.
module fsvh_fu_model
  import fsvh_pkg::*;
(
  input  wire fsvh_pkg::fsvh_iss_t iss_i,
  input  wire logic [63:0]         res_i,
  input  wire logic                tiny_i,
  input  wire logic                inexact_i,
  input  wire logic                oor_i,
  output fsvh_pkg::fsvh_fu_t       fu_o
);
  // Outside an issue cycle the answer is inverted, so a sample taken in the wrong cycle shows up.
  always_comb begin
    fu_o.result       = iss_i.valid ? res_i : ~res_i;
    fu_o.tiny         = iss_i.valid ? tiny_i : ~tiny_i;
    fu_o.inexact      = iss_i.valid ? inexact_i : ~inexact_i;
    fu_o.out_of_range = iss_i.valid ? oor_i : ~oor_i;
  end
endmodule // fsvh_fu_model

/* verif/fsvh_top_test.sv */
// Self-checking testbench for the special-value handling block.
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end \
end

module fsvh_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsvh_pkg::*;

  localparam logic [63:0] ONE  = 64'h0000_0000_3F80_0000;
  localparam logic [63:0] DONE = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] SUB  = 64'h0000_0000_8000_0001;
  localparam logic [63:0] SUBR = 64'h0000_0000_8000_0010;
  localparam logic [63:0] NZ   = 64'h0000_0000_8000_0000;

  logic        mclk_i           = 1'b0;
  logic        rst_i            = 1'b1;
  logic        ce_i             = 1'b1;
  logic [3:0]  avs_address_i    = 4'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        req_valid_i      = 1'b0;
  fsvh_req_t   req_i            = '0;
  fsvh_iss_t   iss_o;
  fsvh_fu_t    fu_i;
  fsvh_wb_t    wb_o;
  logic        exc_event_o;
  logic [63:0] fres             = 64'h0;
  logic        ftiny            = 1'b0;
  logic        finx             = 1'b0;
  logic        foor             = 1'b0;
  fsvh_iss_t   iss_s;
  fsvh_wb_t    wb_s;
  logic        exc_s;
  logic [31:0] rd;
  int          num_errors       = 0;
  int          n_compared       = 0;
  fsvh_op_t    exempt[10]       = '{register_move_op, conditional_move_op, bitwise_and_op, bitwise_or_op,
                                    operand_test_op, int32_to_float_op, int64_to_float_op,
                                    signaling_compare_op, quiet_compare_op, transfer_op};

  fsvh_top dut (
    .mclk_i            (mclk_i),
    .rst_i             (rst_i),
    .ce_i              (ce_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .req_valid_i       (req_valid_i),
    .req_i             (req_i),
    .iss_o             (iss_o),
    .fu_i              (fu_i),
    .wb_o              (wb_o),
    .exc_event_o       (exc_event_o)
  );

  fsvh_fu_model fu_model (
    .iss_i     (iss_o),
    .res_i     (fres),
    .tiny_i    (ftiny),
    .inexact_i (finx),
    .oor_i     (foor),
    .fu_o      (fu_i)
  );

  always #2 mclk_i = ~mclk_i;

  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    num_errors++;
    $display("MISMATCH handshake expected 1 seen 0");
    summarize();
  endtask

  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
    int i;
    @(posedge mclk_i);
    avs_address_i   <= addr;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (i == 16) timeout();
  endtask

  task automatic rchk(input logic [3:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    `CHK("register", exp, rd)
  endtask

  // Issues one operation and captures the issue and write-back stages.
  task automatic run(input fsvh_op_t op, input logic dp, input logic [63:0] a, input logic [63:0] b,
                     input logic [63:0] c, input logic [63:0] res, input logic [2:0] tio);
    int i;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_i       <= '{op: op, dp: dp, a: a, b: b, c: c};
    fres        <= res;
    {ftiny, finx, foor} <= tio;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      if (iss_o.valid === 1'b1) iss_s = iss_o;
      if (wb_o.valid === 1'b1) break;
    end
    wb_s  = wb_o;
    exc_s = exc_event_o;
    if (i == 8) timeout();
  endtask

  task automatic op_chk(input fsvh_op_t op, input logic dp, input logic [63:0] a, input logic [63:0] b,
                        input logic [63:0] c, input logic [63:0] res, input logic [2:0] tio,
                        input logic [63:0] er, input logic [6:0] ef, input logic ee);
    run(op, dp, a, b, c, res, tio);
    `CHK("result", er, wb_s.result)
    `CHK("flags", ef, wb_s.flags)
    `CHK("event", ee, exc_s)
  endtask

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(CTRL_ADDR, CTRL_RESET);
    rchk(STAT_ADDR, STAT_RESET);
    rchk(4'h8, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
    bus(1'b1, 4'hC, 32'h0000_0000);
    rchk(CTRL_ADDR, CTRL_WMASK);
    bus(1'b1, STAT_ADDR, 32'hFFFF_FFFF);
    rchk(STAT_ADDR, STAT_WMASK);
    bus(1'b1, STAT_ADDR, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'h0);
    // All exceptions unmasked, then underflow/inexact masked, then invalid masked: only an unmasked raised flag pulses the event.
    op_chk(arith_op, 1'b0, 64'hFF80_0123, ONE, 64'h0, ONE, 3'h0, 64'hFFC0_0123, 7'h01, 1'b1);
    op_chk(arith_op, 1'b0, ONE, 64'h7FC0_0055, 64'h0, ONE, 3'h0, 64'h7FC0_0055, 7'h00, 1'b0);
    op_chk(arith_op, 1'b1, 64'h7FF0_0000_0000_0ABC, DONE, 64'h0, DONE, 3'h0,
           64'h7FF8_0000_0000_0ABC, 7'h01, 1'b1);
    op_chk(fused_multiply_accumulate, 1'b0, 64'h0, 64'h7F80_0000, ONE, ONE, 3'h0,
           SP_DEFAULT_NAN, 7'h01, 1'b1);
    op_chk(fused_multiply_accumulate, 1'b1, 64'h8000_0000_0000_0000, 64'hFFF0_0000_0000_0000, DONE, DONE, 3'h0,
           DP_DEFAULT_NAN, 7'h01, 1'b1);
    op_chk(float_to_int32_op, 1'b0, 64'h7FC0_0000, ONE, 64'h0, 64'h7FFF_FFFF, 3'h1, 64'h7FFF_FFFF, 7'h01, 1'b1);
    op_chk(float_to_int64_op, 1'b1, 64'hFFF0_0000_0000_0000, DONE, 64'h0, 64'h1, 3'h1, 64'h1, 7'h01, 1'b1);
    op_chk(float_to_int32_op, 1'b0, 64'h4F80_0000, ONE, 64'h0, 64'h7FFF_FFFF, 3'h1, 64'h7FFF_FFFF, 7'h20, 1'b1);
    op_chk(arith_op, 1'b0, SUB, ONE, 64'h0, ONE, 3'h0, ONE, 7'h40, 1'b1);
    `CHK("operand", SUB, iss_s.a)
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, SUBR, 3'h0, SUBR, 7'h08, 1'b1);
    op_chk(arith_op, 1'b1, DONE, DONE, 64'h0, 64'h8000_0000_0000_0001, 3'h0,
           64'h8000_0000_0000_0001, 7'h08, 1'b1);
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, NZ, 3'h4, NZ, 7'h18, 1'b1);
    bus(1'b1, CTRL_ADDR, 32'h0000_0400);
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, SUBR, 3'h0, SUBR, 7'h08, 1'b1);
    bus(1'b1, CTRL_ADDR, 32'h0000_0418);
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, SUBR, 3'h0, NZ, 7'h18, 1'b0);
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, NZ, 3'h4, NZ, 7'h18, 1'b0);
    bus(1'b1, CTRL_ADDR, 32'h0000_0001);
    op_chk(arith_op, 1'b0, 64'h7F80_0123, ONE, 64'h0, ONE, 3'h0, 64'h7FC0_0123, 7'h01, 1'b0);
    // Operand zeroing with rounding mode 3 selected.
    bus(1'b1, CTRL_ADDR, 32'h0000_0B00);
    op_chk(arith_op, 1'b0, SUB, ONE, 64'h0, ONE, 3'h0, ONE, 7'h00, 1'b0);
    `CHK("operand", NZ, iss_s.a)
    `CHK("rounding", 2'h3, iss_s.rnd)
    run(negate_op, 1'b0, SUB, ONE, 64'h0, ONE, 3'h0);
    `CHK("operand", NZ, iss_s.a)
    run(absolute_value_op, 1'b1, 64'h8000_0000_0000_0001, DONE, 64'h0, DONE, 3'h0);
    `CHK("operand", 64'h8000_0000_0000_0000, iss_s.a)
    run(fused_multiply_accumulate, 1'b0, ONE, SUB, SUB, ONE, 3'h0);
    `CHK("operand b", NZ, iss_s.b)
    `CHK("operand c", NZ, iss_s.c)
    foreach (exempt[k]) begin
      run(exempt[k], 1'b0, SUB, SUB, 64'h0, ONE, 3'h0);
      `CHK("operand", SUB, iss_s.a)
      `CHK("operand b", SUB, iss_s.b)
    end
    // Sticky history survives a clean operation.
    bus(1'b1, CTRL_ADDR, 32'h0);
    bus(1'b1, STAT_ADDR, 32'h0);
    op_chk(arith_op, 1'b0, SUB, ONE, 64'h0, ONE, 3'h0, ONE, 7'h40, 1'b1);
    op_chk(arith_op, 1'b0, ONE, ONE, 64'h0, ONE, 3'h0, ONE, 7'h00, 1'b0);
    rchk(STAT_ADDR, 32'h0000_4000);
    summarize();
  end
endmodule // fsvh_top_test
